// File: design/fanmon_pkg.sv
/*
  Shared constants and carrier types of the fan tachometer monitor.
  Assumes a 250 MHz system clock and an APB register port.
*/
package fanmon_pkg;

  // APB carrier
  localparam int FANMON_AW = 12;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [FANMON_AW-1:0] paddr;
    logic [31:0] pwdata;
  } fanmon_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } fanmon_apb_rsp_t;

  // Register byte offsets
  localparam logic [FANMON_AW-1:0] FANMON_CTRL_OFS = 12'h000;
  localparam logic [FANMON_AW-1:0] FANMON_STAT_OFS = 12'h004;
  localparam logic [FANMON_AW-1:0] FANMON_HIGH_OFS = 12'h008;
  localparam logic [FANMON_AW-1:0] FANMON_LOW_OFS = 12'h00c;

  // Control register fields
  localparam int FANMON_CTRL_EN_BIT = 0;
  localparam int FANMON_CTRL_MODE_BIT = 1;
  localparam int FANMON_CTRL_EDGES_LSB = 11;
  localparam int FANMON_CTRL_CRIE_BIT = 14;
  localparam int FANMON_CTRL_TGIE_BIT = 15;
  localparam int FANMON_CTRL_READ_LSB = 16;

  // Status register fields
  localparam int FANMON_STAT_LIM_BIT = 0;
  localparam int FANMON_STAT_TGL_BIT = 1;
  localparam int FANMON_STAT_PIN_BIT = 2;
  localparam int FANMON_STAT_CR_BIT = 3;

  // Reset values and counter maximum
  localparam logic [15:0] FANMON_READ_RST = 16'h0000;
  localparam logic [15:0] FANMON_HIGH_RST = 16'hffff;
  localparam logic [15:0] FANMON_LOW_RST = 16'h0000;
  localparam logic [15:0] FANMON_CNT_MAX = 16'hffff;

  // Edge-count selection encodings
  localparam logic [1:0] FANMON_EDGES_2 = 2'b00;
  localparam logic [1:0] FANMON_EDGES_3 = 2'b01;
  localparam logic [1:0] FANMON_EDGES_5 = 2'b10;
  localparam logic [1:0] FANMON_EDGES_9 = 2'b11;

  // Measuring clock derived from the system clock
  localparam int FANMON_SYS_PERIOD_PS = 4000;
  localparam int FANMON_TICK_PERIOD_NS = 10000;
  localparam int FANMON_TICK_CYCLES =
    (FANMON_TICK_PERIOD_NS * 1000) / FANMON_SYS_PERIOD_PS;

  // Power state, one-hot
  typedef enum logic [1:0] {
    FANMON_RUN = 2'b01,
    FANMON_SLEEP = 2'b10
  } fanmon_pwr_t;

endpackage

// File: design/fanmon_sync_edge.sv
/*
  Two-flop synchroniser with edge detection for the tachometer pin.
  Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
module fanmon_sync_edge (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic toggle
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // Only sync_q reads meta_q; edges come from the settled stages
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // One pulse per edge, so every edge counts once
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign toggle = sync_q ^ last_q;

endmodule

// File: design/fanmon_top.sv
/*
  Fan tachometer monitor: edge counter or 100 kHz period counter, limit
  check, status flags, interrupt and APB register slave.
  Assumes an APB master on clock and an asynchronous tachometer pin.
*/
// The implementer's own choice: the APB slave port.
// Behaviour
// - Two modes chosen by one mode bit
// - Mode 0 counts rising edges of input
// - Mode 0 counter wraps to zero, continues
// - Mode 1 counts 100 kHz ticks per window
// - Mode 1 latches reading, sets count ready
// - Count ready with enable raises interrupt
// - Reading outside limits sets violation flag
// - Violation flag always raises interrupt
// - Interrupt is OR of status events
// - System reset restores all defaults
// - Clearing enable stops monitoring
// - Low-power request enters sleep state
// - Control, status, high, low at 00..0C
// - Edge field selects 2, 3, 5, 9
// - Mode 1 saturates at max, then clears
// - Mode 0 reading follows every increment
// - Reading is read-only upper control half
`timescale 1ns/1ps
module fanmon_top
  import fanmon_pkg::*;
#(
  parameter int TICK_CYCLES = FANMON_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire fanmon_apb_req_t apb_req,
  output fanmon_apb_rsp_t apb_rsp,
  input wire logic tach_pin,
  input wire logic lp_req,
  output logic lp_ack,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic pin_level;
  logic pin_rise;
  logic pin_toggle;

  // Edges are seen only after two flops
  fanmon_sync_edge u_sync (
    .clock(clock),
    .rst(rst),
    .pin(tach_pin),
    .level(pin_level),
    .rise(pin_rise),
    .toggle(pin_toggle)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register state

  logic enable_q;
  logic mode_q;
  logic [1:0] edges_q;
  logic crie_q;
  logic tgie_q;
  logic [15:0] reading_q;
  logic [15:0] high_q;
  logic [15:0] low_q;
  logic lim_q;
  logic tgl_q;
  logic cr_q;
  fanmon_pwr_t pwr_q;
  fanmon_pwr_t pwr_d;

  ////////////////////////////////////////////////////////////////////////
  // Power state

  // Sleep follows the request level; no handshake beyond the ack
  always_comb begin
    case (pwr_q)
      FANMON_RUN: pwr_d = lp_req ? FANMON_SLEEP : FANMON_RUN;
      FANMON_SLEEP: pwr_d = lp_req ? FANMON_SLEEP : FANMON_RUN;
      default: pwr_d = FANMON_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pwr_q <= FANMON_RUN;
      lp_ack <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      lp_ack <= (pwr_d == FANMON_SLEEP);
    end
  end

  // Monitoring runs only when enabled and awake
  wire active = enable_q & (pwr_q == FANMON_RUN);

  ////////////////////////////////////////////////////////////////////////
  // 100 kHz tick divider

  logic [15:0] div_q;
  localparam logic [15:0] DIV_LAST = 16'(TICK_CYCLES - 1);
  wire div_wrap = (div_q == DIV_LAST);
  wire tick = active & div_wrap;

  // Held at zero while idle so a window starts on a fresh period
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_wrap ? 16'h0000 : div_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Measurement counter

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [3:0] ecnt_q;
  logic [3:0] ecnt_d;
  logic latch;
  logic [15:0] latch_val;
  logic cr_set;
  logic [3:0] target;

  // Edges per Mode 1 window
  always_comb begin
    case (edges_q)
      FANMON_EDGES_2: target = 4'h2;
      FANMON_EDGES_3: target = 4'h3;
      FANMON_EDGES_5: target = 4'h5;
      FANMON_EDGES_9: target = 4'h9;
      default: target = 4'h2;
    endcase
  end

  // Counting per mode; only a window's first or last edge drops a tick
  always_comb begin
    cnt_d = cnt_q;
    ecnt_d = ecnt_q;
    latch = 1'b0;
    latch_val = cnt_q;
    cr_set = 1'b0;
    if (!active) begin
      ecnt_d = 4'h0;
      if (mode_q) begin
        cnt_d = 16'h0000;
      end
    end else if (!mode_q) begin
      if (pin_rise) begin
        cnt_d = cnt_q + 16'h0001;
        latch = 1'b1;
        latch_val = cnt_q + 16'h0001;
      end
    end else if (pin_toggle && ecnt_q == 4'h0) begin
      ecnt_d = 4'h1;
      cnt_d = 16'h0000;
    end else if (pin_toggle && ecnt_q + 4'h1 == target) begin
      latch = 1'b1;
      cr_set = 1'b1;
      cnt_d = 16'h0000;
      ecnt_d = 4'h1;
    end else begin
      // Inner edges advance the window without losing a tick
      if (pin_toggle) begin
        ecnt_d = ecnt_q + 4'h1;
      end
      if (tick && ecnt_q != 4'h0) begin
        if (cnt_q == FANMON_CNT_MAX) begin
          latch = 1'b1;
          latch_val = FANMON_CNT_MAX;
          cnt_d = 16'h0000;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= FANMON_READ_RST;
      ecnt_q <= 4'h0;
      reading_q <= FANMON_READ_RST;
    end else begin
      cnt_q <= cnt_d;
      ecnt_q <= ecnt_d;
      if (latch) begin
        reading_q <= latch_val;
      end
    end
  end

  // Limits checked against the value being latched
  wire over = (latch_val > high_q);
  wire under = (latch_val < low_q);
  wire lim_set = latch & (over | under);

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  wire setup = apb_req.psel & ~apb_req.penable;
  wire access = apb_req.psel & apb_req.penable;
  wire done = access & apb_rsp.pready;
  wire hit_ctrl = (apb_req.paddr == FANMON_CTRL_OFS);
  wire hit_stat = (apb_req.paddr == FANMON_STAT_OFS);
  wire hit_high = (apb_req.paddr == FANMON_HIGH_OFS);
  wire hit_low = (apb_req.paddr == FANMON_LOW_OFS);
  wire hit_any = hit_ctrl | hit_stat | hit_high | hit_low;
  wire wr = done & apb_req.pwrite & hit_any;
  wire [31:0] wdata = apb_req.pwdata;

  // Write-one-to-clear; hardware set wins over a clear
  wire lim_clr = wr & hit_stat & wdata[FANMON_STAT_LIM_BIT];
  wire tgl_clr = wr & hit_stat & wdata[FANMON_STAT_TGL_BIT];
  wire cr_clr = wr & hit_stat & wdata[FANMON_STAT_CR_BIT];
  wire tgl_set = active & pin_toggle;

  wire [31:0] ctrl_rd = {reading_q, tgie_q, crie_q, 1'b0, edges_q,
    9'h000, mode_q, enable_q};
  wire [31:0] stat_rd = {28'h000_0000, cr_q, pin_level, tgl_q, lim_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
    hit_stat ? stat_rd :
    hit_high ? {16'h0000, high_q} :
    hit_low ? {16'h0000, low_q} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Control and limit registers

  // Reading field is not writable
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_q <= 1'b0;
      mode_q <= 1'b0;
      edges_q <= FANMON_EDGES_2;
      crie_q <= 1'b0;
      tgie_q <= 1'b0;
    end else if (wr && hit_ctrl) begin
      enable_q <= wdata[FANMON_CTRL_EN_BIT];
      mode_q <= wdata[FANMON_CTRL_MODE_BIT];
      edges_q <= wdata[FANMON_CTRL_EDGES_LSB +: 2];
      crie_q <= wdata[FANMON_CTRL_CRIE_BIT];
      tgie_q <= wdata[FANMON_CTRL_TGIE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      high_q <= FANMON_HIGH_RST;
      low_q <= FANMON_LOW_RST;
    end else begin
      if (wr && hit_high) begin
        high_q <= wdata[15:0];
      end
      if (wr && hit_low) begin
        low_q <= wdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  always_ff @(posedge clock) begin
    if (rst) begin
      lim_q <= 1'b0;
      tgl_q <= 1'b0;
      cr_q <= 1'b0;
    end else begin
      lim_q <= lim_set | (lim_q & ~lim_clr);
      tgl_q <= tgl_set | (tgl_q & ~tgl_clr);
      cr_q <= cr_set | (cr_q & ~cr_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt

  // Mode 0 still raises events; firmware is expected to mask them
  wire irq_d = lim_q | (cr_q & crie_q) | (tgl_q & tgie_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB response

  // One wait state: pready rises in the first access cycle's next edge
  always_ff @(posedge clock) begin
    if (rst) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= access & ~apb_rsp.pready & ~setup;
      if (access && !apb_rsp.pready) begin
        apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
        apb_rsp.pslverr <= ~hit_any;
      end else if (done) begin
        apb_rsp.prdata <= 32'h0000_0000;
        apb_rsp.pslverr <= 1'b0;
      end
    end
  end

endmodule

// File: sim/fanmon_props.sv
/*
  Port checker for fanmon_top, bound from the bench.
  Assumes one clock domain and synchronous reset.
*/
`timescale 1ns/1ps
module fanmon_props
  import fanmon_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire fanmon_apb_req_t apb_req,
  input wire fanmon_apb_rsp_t apb_rsp,
  input wire logic tach_pin,
  input wire logic lp_req,
  input wire logic lp_ack,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Write history: irq may only drop after a register write
  logic wr_q;
  logic wr2_q;
  wire wr_d = apb_req.psel & apb_req.pwrite & apb_rsp.pready;
  wire bad_a = (apb_req.paddr[11:4] != 0) | (apb_req.paddr[1:0] != 0);
  always_ff @(posedge clock) begin
    wr_q <= wr_d;
    wr2_q <= wr_q;
  end
  sequence s_wait;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  sequence s_done;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  chk_ready_wait: assert property (s_wait |=> s_done)
    else $error("pready not one wait state");
  chk_ready_cause: assert property (apb_rsp.pready |->
    $past(apb_req.psel && apb_req.penable))
    else $error("pready without access");
  chk_idle_quiet: assert property (!apb_rsp.pready |->
    apb_rsp.prdata == 0 && !apb_rsp.pslverr)
    else $error("response outside pready");
  chk_unmap_err: assert property (apb_rsp.pready |->
    apb_rsp.pslverr == bad_a)
    else $error("pslverr wrong for address");
  chk_unmap_zero: assert property (apb_rsp.pready &&
    apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == 0)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !irq && !lp_ack && !apb_rsp.pready)
    else $error("outputs active after reset");
  chk_lp_follow: assert property (lp_ack == $past(lp_req))
    else $error("lp_ack not one cycle behind");
  chk_irq_drop: assert property ($fell(irq) |-> wr_q || wr2_q)
    else $error("irq fell without write");
endmodule

// File: sim/fanmon_fan_model.sv
/*
  Fan model: square wave on tach_pin, half period in clocks.
  Assumes the bench drives run and half after a clock edge.
*/
`timescale 1ns/1ps
module fanmon_fan_model (
  input wire logic clock,
  input wire logic run,
  input wire logic [15:0] half,
  output logic tach_pin
);
  int cnt = 0;
  logic pin_q = 1'b0;
  // One driver for the pin, starting low
  assign tach_pin = pin_q;
  ////////////////////////////////////////
  // Stalled rotor: pin stands still while run is low
  always @(posedge clock) begin
    if (run) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= half) begin
        cnt <= 0;
        pin_q <= ~pin_q;
      end
    end
  end
endmodule

// File: sim/tb_fanmon_top.sv
/*
  Bench for fanmon_top: APB master, fan model, scenarios.
  Assumes TICK_CYCLES of 5 so Mode 1 windows stay short.
*/
`timescale 1ns/1ps
module tb_fanmon_top
  import fanmon_pkg::*;
;
  localparam int TK = 5;
  localparam int HP = 52;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  fanmon_apb_req_t apb_req = '0;
  fanmon_apb_rsp_t apb_rsp;
  logic tach_pin;
  logic lp_req = 1'b0;
  logic lp_ack;
  logic irq;
  logic run = 1'b0;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int samples_checked = 0;
  int rises = 0;
  always #2 clock = ~clock;
  always @(posedge tach_pin) rises++;
  fanmon_top #(.TICK_CYCLES(TK)) i_fanmon_top (.clock(clock), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .tach_pin(tach_pin),
    .lp_req(lp_req), .lp_ack(lp_ack), .irq(irq));
  fanmon_fan_model i_fanmon_fan_model (.clock(clock), .run(run),
    .half(16'(HP)), .tach_pin(tach_pin));
  ////////////////////////////////////////
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      cmp(ZERO, 32'h0000_0001);
      results();
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clock);
  endtask
  task automatic run_fan(int cyc);
    run <= 1'b1;
    repeat (cyc) @(posedge clock);
    run <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  // Defaults and unmapped space
  task automatic t_reset();
    apb(0, FANMON_CTRL_OFS, ZERO);
    cmp(rd, ZERO);
    apb(0, FANMON_HIGH_OFS, ZERO);
    cmp(rd, 32'h0000_ffff);
    apb(0, FANMON_LOW_OFS, ZERO);
    cmp(rd, ZERO);
    apb(0, FANMON_STAT_OFS, ZERO);
    cmp(rd & 32'hffff_fffb, ZERO);
    apb(1, 12'h010, 32'h0000_0001);
    cmp(er, 1'b1);
    apb(0, 12'h010, ZERO);
    cmp(rd, ZERO);
  endtask
  // Edge counting, interrupts left off, reading is read-only
  task automatic t_mode0();
    int r0;
    r0 = rises;
    apb(1, FANMON_CTRL_OFS, 32'h0000_0001);
    run_fan(20 * HP);
    apb(0, FANMON_CTRL_OFS, ZERO);
    cmp(rd[31:16], 16'(rises - r0));
    apb(1, FANMON_CTRL_OFS, 32'hffff_0001);
    apb(0, FANMON_CTRL_OFS, ZERO);
    cmp(rd[31:16], 16'(rises - r0));
  endtask
  // Sleep, then disable: nothing counted
  task automatic t_pause();
    logic [15:0] r0;
    apb(0, FANMON_CTRL_OFS, ZERO);
    r0 = rd[31:16];
    lp_req <= 1'b1;
    run_fan(10 * HP + HP / 2);
    cmp(lp_ack, 1'b1);
    lp_req <= 1'b0;
    repeat (2) @(posedge clock);
    apb(0, FANMON_CTRL_OFS, ZERO);
    cmp(rd[31:16], r0);
    apb(1, FANMON_CTRL_OFS, ZERO);
    run_fan(10 * HP);
    apb(0, FANMON_CTRL_OFS, ZERO);
    cmp(rd[31:16], r0);
  endtask
  // Period counting for every edge code, limits and masking
  task automatic t_mode1();
    int e[4] = '{2, 3, 5, 9};
    int x;
    int n;
    for (int c = 0; c < 4; c++) begin
      x = (e[c] - 1) * HP / TK;
      apb(1, FANMON_HIGH_OFS, (c == 3) ? 32'h0000_0014 : 32'h0000_ffff);
      apb(1, FANMON_LOW_OFS, (c == 0) ? 32'h0000_0064 : ZERO);
      apb(1, FANMON_CTRL_OFS, 32'h0000_0003 | (c << 11) |
        (c != 1 ? 32'h0000_4000 : ZERO));
      run <= 1'b1;
      n = 0;
      do begin
        apb(0, FANMON_STAT_OFS, ZERO);
        n++;
      end while (rd[3] !== 1'b1 && n < 400);
      cmp(rd[3], 1'b1);
      if (n >= 400) results();
      apb(0, FANMON_CTRL_OFS, ZERO);
      cmp(rd[31:16] + 2 >= x && rd[31:16] <= x + 2, 1'b1);
      apb(0, FANMON_STAT_OFS, ZERO);
      cmp(rd[0], c == 0 || c == 3);
      cmp(irq, c != 1);
      apb(1, FANMON_CTRL_OFS, ZERO);
      run <= 1'b0;
      apb(1, FANMON_STAT_OFS, 32'h0000_000b);
      repeat (3) @(posedge clock);
      cmp(irq, 1'b0);
    end
  endtask
  // Toggle event and pin level, then a reset in mid-run
  task automatic t_toggle();
    apb(1, FANMON_CTRL_OFS, 32'h0000_8003);
    run_fan(HP);
    apb(0, FANMON_STAT_OFS, ZERO);
    cmp(rd[2:1], {tach_pin, 1'b1});
    cmp(irq, 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    cmp(irq, 1'b0);
    t_reset();
  endtask
  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_mode0();
    t_pause();
    t_mode1();
    t_toggle();
    results();
  end
endmodule
bind fanmon_top fanmon_props i_fanmon_props (.clock(clock), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .tach_pin(tach_pin),
  .lp_req(lp_req), .lp_ack(lp_ack), .irq(irq));
